// ==== tb/p6io_board.sv ====
// board model: external drivers on the eight port pins
`timescale 1ns/1ns
`default_nettype none
module p6io_board (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] extDrive,
  output var  logic [7:0] pinLevel
);
  // board drivers yield wherever the port drives the pin
  assign pinLevel = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule
`default_nettype wire

// ==== tb/p6io_port_bench.sv ====
// testbench: register access, pin functions and reset behaviour of the port block
`timescale 1ns/1ns
`default_nettype none
module p6io_port_bench;
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] dir;
    logic [7:0] dat;
    logic [7:0] alt;
    logic [7:0] ext;
    logic [7:0] oe;
    logic [7:0] drv;
    logic [7:0] pst;
    logic [4:0] req;
  } p6io_row_type;
  logic                       clk_sys = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       hwStby = 1'b0;
  logic                       manRst = 1'b0;
  logic [11:0]                awA = 12'h000;
  logic [11:0]                arA = 12'h000;
  logic [31:0]                wD = 32'h0000_0000;
  logic [31:0]                rD;
  logic [31:0]                got;
  logic                       awV = 1'b0;
  logic                       wV = 1'b0;
  logic                       bR = 1'b0;
  logic                       arV = 1'b0;
  logic                       rR = 1'b0;
  logic                       awR, wR, bV, arR, rV;
  logic [1:0]                 bResp, rResp, rsp;
  logic [7:0]                 pinOut, pinOe, pinLvl;
  logic [7:0]                 ext = 8'h00;
  p6io_pkg::p6io_alt_in_type  altIn = '0;
  p6io_pkg::p6io_alt_out_type altOut;
  int                         mismatches = 0;
  int                         n_compared = 0;
  int                         cycles = 0;
  // mode, dir, data, alt, pins; expected oe, driven bits, pin state, requests
  p6io_row_type rows [7] = '{
    '{3'h1, 8'hF0, 8'hA5, 8'h00, 8'h3C, 8'hF0, 8'hA0, 8'hAC, 5'h09},
    '{3'h4, 8'hC3, 8'h00, 8'h05, 8'hFF, 8'hC3, 8'h41, 8'h3C, 5'h1F},
    '{3'h5, 8'h3C, 8'h14, 8'hF0, 8'h00, 8'h3E, 8'h1E, 8'h16, 5'h11},
    '{3'h6, 8'hFF, 8'hFF, 8'h0A, 8'h00, 8'hFF, 8'hBE, 8'hFF, 5'h19},
    '{3'h7, 8'h0F, 8'h5A, 8'h40, 8'hC3, 8'h0F, 8'h02, 8'hCA, 5'h04},
    '{3'h2, 8'h00, 8'hFF, 8'h80, 8'h55, 8'h02, 8'h00, 8'h55, 5'h17},
    '{3'h3, 8'hAA, 8'h0F, 8'h0F, 8'hFF, 8'hAA, 8'h0A, 8'h5F, 5'h17}
  };
  initial forever #10 clk_sys = ~clk_sys;
  p6io_port DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .hwStandby(hwStby),
    .manualRst(manRst), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR),
    .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wR),
    .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA),
    .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rResp),
    .s_axi_rvalid(rV), .s_axi_rready(rR), .pinIn(pinLvl), .pinOut(pinOut),
    .pinOe(pinOe), .altIn(altIn), .altOut(altOut));
  p6io_board board (.pinOut(pinOut), .pinOe(pinOe), .extDrive(ext), .pinLevel(pinLvl));
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bR <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awR) awV <= 1'b0;
      if (wR) wV <= 1'b0;
      if (bV) break;
    end
    bR <= 1'b0;
    rsp = bResp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    arA <= a;
    arV <= 1'b1;
    rR <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arR) arV <= 1'b0;
      if (rV) break;
    end
    rR <= 1'b0;
    got = rD;
    rsp = rResp;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e, input string n);
    rd(a);
    cmp(n, {24'h00_0000, e}, got);
    cmp({n, " resp"}, 32'(p6io_pkg::RESP_OKAY), 32'(rsp));
  endtask
  // pin path: drive register, two sync stages, then the sampled state
  task automatic settle();
    repeat (5) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    ext <= 8'h5A;
    settle();
    cmp("oe reset", 32'h0000_0000, 32'(pinOe));
    rc(p6io_pkg::ADDR_OUTPUT_DATA, 8'h00, "data reset");
    rc(p6io_pkg::ADDR_PIN_STATE, 8'h5A, "pins reset");
    foreach (rows[i]) begin
      wr(p6io_pkg::ADDR_CONTROL, {29'h0000_0000, rows[i].mode});
      wr(p6io_pkg::ADDR_DIRECTION, {24'h00_0000, rows[i].dir});
      wr(p6io_pkg::ADDR_OUTPUT_DATA, {24'h00_0000, rows[i].dat});
      altIn <= p6io_pkg::p6io_alt_in_type'(rows[i].alt);
      ext <= rows[i].ext;
      settle();
      cmp("oe", 32'(rows[i].oe), 32'(pinOe));
      cmp("drive", 32'(rows[i].drv), 32'(pinOut & pinOe));
      cmp("alt", 32'(rows[i].req), 32'(altOut));
      rc(p6io_pkg::ADDR_PIN_STATE, rows[i].pst, "pins");
      rc(p6io_pkg::ADDR_OUTPUT_DATA, rows[i].dat, "data");
    end
    rc(p6io_pkg::ADDR_DIRECTION, 8'h00, "dir read");
    wr(p6io_pkg::ADDR_PIN_STATE, 32'h0000_00FF);
    cmp("pins wr resp", 32'(p6io_pkg::RESP_OKAY), 32'(rsp));
    rc(p6io_pkg::ADDR_PIN_STATE, 8'h5F, "pins wr");
    rc(p6io_pkg::ADDR_OUTPUT_DATA, 8'h0F, "data wr");
    rd(12'h010);
    cmp("unmapped", 32'(p6io_pkg::RESP_SLVERR), 32'(rsp));
    cmp("unmapped data", 32'h0000_0000, got);
    wr(12'h010, 32'h0000_00FF);
    cmp("unmapped wr", 32'(p6io_pkg::RESP_SLVERR), 32'(rsp));
    wr(p6io_pkg::ADDR_DIRECTION, 32'h0000_0000);
    ext <= 8'h11;
    settle();
    manRst <= 1'b1;
    settle();
    ext <= 8'hEE;
    settle();
    rc(p6io_pkg::ADDR_PIN_STATE, 8'h11, "pins man");
    rc(p6io_pkg::ADDR_OUTPUT_DATA, 8'h0F, "data man");
    manRst <= 1'b0;
    settle();
    rc(p6io_pkg::ADDR_PIN_STATE, 8'hEE, "pins man off");
    wr(p6io_pkg::ADDR_CONTROL, 32'h0000_0013);
    ext <= 8'h22;
    settle();
    rc(p6io_pkg::ADDR_PIN_STATE, 8'hEE, "pins sw");
    rc(p6io_pkg::ADDR_OUTPUT_DATA, 8'h0F, "data sw");
    wr(p6io_pkg::ADDR_CONTROL, 32'h0000_0003);
    wr(p6io_pkg::ADDR_DIRECTION, 32'h0000_00FF);
    hwStby <= 1'b1;
    settle();
    cmp("oe hw", 32'h0000_0000, 32'(pinOe));
    hwStby <= 1'b0;
    settle();
    rc(p6io_pkg::ADDR_OUTPUT_DATA, 8'h00, "data hw");
    rc(p6io_pkg::ADDR_PIN_STATE, 8'h22, "pins hw");
    // power-on reset in mid-run must clear what software left behind
    wr(p6io_pkg::ADDR_OUTPUT_DATA, 32'h0000_00A5);
    wr(p6io_pkg::ADDR_DIRECTION, 32'h0000_00FF);
    ext <= 8'h3C;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    cmp("oe por", 32'h0000_0000, 32'(pinOe));
    rc(p6io_pkg::ADDR_OUTPUT_DATA, 8'h00, "data por");
    rc(p6io_pkg::ADDR_PIN_STATE, 8'h3C, "pins por");
    finish_test();
  end
endmodule
`default_nettype wire

// ==== verilog/p6io_pkg.sv ====
// package: register map, field layout and carrier types of the port 6 block
// Operation
// - 8-bit read/write output data register drives pins set as general outputs.
// - output data clears to zero on power-on reset and hardware standby.
// - output data survives manual reset and software standby unchanged.
// - pin-state register is read-only; writes to it are ignored.
// - pin-state read gives output data where direction is 1, pin level else.
// - pin-state follows pins after power-on/hw standby, holds through manual/sw standby.
// - pin 7: general I/O in modes 1,2,3,7; input or chip-select 7 in 4-6.
// - pin 6: like pin 7 with chip-select 6; always feeds external interrupt 2.
// - pin 5: general I/O in all modes; always feeds external interrupt 1.
// - pin 4: general I/O in all modes; always feeds external interrupt 0.
// - pin 3: transfer-end 1 output when its enable is 1, else general I/O.
// - pin 1: transfer-end 0 if enabled; else general I/O or chip-select 5.
// - pin 0: general I/O or chip-select 4 by mode; feeds DMA request 0.
// - direction 1 means output, 0 input; clears to zero on power-on reset.
// - direction register is write-only; reads return an undefined value.
package p6io_pkg;
  localparam logic [11:0] ADDR_DIRECTION   = 12'h000;
  localparam logic [11:0] ADDR_OUTPUT_DATA = 12'h004;
  localparam logic [11:0] ADDR_PIN_STATE   = 12'h008;
  localparam logic [11:0] ADDR_CONTROL     = 12'h00C;
  localparam logic [7:0]  RESET_BYTE       = 8'h00;
  localparam logic [31:0] UNDEF_READ       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SW_STBY  = 4;
  localparam logic [2:0] MODE_RESET = 3'h1;
  localparam int PIN_CS7 = 7;
  localparam int PIN_CS6 = 6;
  localparam int PIN_INT2 = 6;
  localparam int PIN_INT1 = 5;
  localparam int PIN_INT0 = 4;
  localparam int PIN_XFER_END_OUT_CH1 = 3;
  localparam int PIN_DMA_REQUEST_CH1 = 2;
  localparam int PIN_XFER_END_OUT_CH0 = 1;
  localparam int PIN_CS5 = 1;
  localparam int PIN_CS4 = 0;
  localparam int PIN_DMA_REQUEST_CH0 = 0;

  typedef struct packed {
    logic       xferEndEnableCh0;
    logic       xferEndEnableCh1;
    logic       xferEndOutCh0N;
    logic       xferEndOutCh1N;
    logic [3:0] chipSelN;
  } p6io_alt_in_type;

  typedef struct packed {
    logic extInt0N;
    logic extInt1N;
    logic extInt2N;
    logic dmaRequestCh0N;
    logic dmaRequestCh1N;
  } p6io_alt_out_type;
endpackage

// ==== verilog/p6io_port.sv ====
// module: port 6 general I/O with shared alternate functions, AXI4-Lite slave
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module p6io_port (
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      hwStandby,
  input  wire logic                      manualRst,
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [7:0]                pinIn,
  output var  logic [7:0]                pinOut,
  output var  logic [7:0]                pinOe,
  input  wire p6io_pkg::p6io_alt_in_type altIn,
  output var  p6io_pkg::p6io_alt_out_type altOut
);
  logic [7:0] portDirection;
  logic [7:0] portOutputData;
  logic [7:0] portPinState;
  logic [2:0] opMode;
  logic       swStandby;
  logic [7:0] pinMeta;
  logic [7:0] pinSync;
  logic       hwStbyMeta;
  logic       hwStby;
  logic       manMeta;
  logic       manRst;
  logic       haveAw;
  logic       haveW;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        csMode;
  logic        holdState;
  logic        doWrite;
  logic [7:0]  next_pinOut;
  logic [7:0]  next_pinOe;

  // two-stage synchronisers for pins and standby/reset strobes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta    <= p6io_pkg::RESET_BYTE;
      pinSync    <= p6io_pkg::RESET_BYTE;
      hwStbyMeta <= 1'b0;
      hwStby     <= 1'b0;
      manMeta    <= 1'b0;
      manRst     <= 1'b0;
    end else begin
      pinMeta    <= pinIn;
      pinSync    <= pinMeta;
      hwStbyMeta <= hwStandby;
      hwStby     <= hwStbyMeta;
      manMeta    <= manualRst;
      manRst     <= manMeta;
    end
  end

  assign csMode    = (opMode >= 3'h4) && (opMode <= 3'h6);
  assign holdState = manRst || swStandby;
  assign doWrite   = haveAw && haveW && !s_axi_bvalid;

  // write channel: address and data taken in either order
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      haveAw        <= 1'b0;
      haveW         <= 1'b0;
      awAddr        <= 12'h000;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= p6io_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !haveAw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !haveW && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        haveAw       <= 1'b0;
        haveW        <= 1'b0;
        unique case (awAddr)
          p6io_pkg::ADDR_DIRECTION, p6io_pkg::ADDR_OUTPUT_DATA,
          p6io_pkg::ADDR_PIN_STATE, p6io_pkg::ADDR_CONTROL: s_axi_bresp <= p6io_pkg::RESP_OKAY;
          default: s_axi_bresp <= p6io_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage; hardware standby clears direction and output data but not control, manual reset keeps
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      portDirection  <= p6io_pkg::RESET_BYTE;
      portOutputData <= p6io_pkg::RESET_BYTE;
      opMode         <= p6io_pkg::MODE_RESET;
      swStandby      <= 1'b0;
    end else if (hwStby) begin
      portDirection  <= p6io_pkg::RESET_BYTE;
      portOutputData <= p6io_pkg::RESET_BYTE;
    end else if (doWrite && wStrb[0]) begin
      // pin-state address decodes but stores nothing
      if (awAddr == p6io_pkg::ADDR_DIRECTION) portDirection <= wData[7:0];
      if (awAddr == p6io_pkg::ADDR_OUTPUT_DATA) portOutputData <= wData[7:0];
      if (awAddr == p6io_pkg::ADDR_CONTROL) begin
        opMode    <= wData[p6io_pkg::CTRL_MODE_LSB +: 3];
        swStandby <= wData[p6io_pkg::CTRL_SW_STBY];
      end
    end
  end

  // pin-state: merge of output data and pin levels, frozen while held
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      portPinState <= p6io_pkg::RESET_BYTE;
    end else if (hwStby || !holdState) begin
      portPinState <= (portDirection & portOutputData)
                    | (~portDirection & pinSync);
    end
  end

  // read channel
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= p6io_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= p6io_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          p6io_pkg::ADDR_DIRECTION:   s_axi_rdata <= p6io_pkg::UNDEF_READ;
          p6io_pkg::ADDR_OUTPUT_DATA: s_axi_rdata <= {24'h00_0000, portOutputData};
          p6io_pkg::ADDR_PIN_STATE:   s_axi_rdata <= {24'h00_0000, portPinState};
          p6io_pkg::ADDR_CONTROL:     s_axi_rdata <= {27'h000_0000, swStandby, 1'b0, opMode};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= p6io_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pin function selection
  always_comb begin
    next_pinOe  = portDirection;
    next_pinOut = portOutputData;
    if (csMode) begin
      next_pinOut[p6io_pkg::PIN_CS7] = altIn.chipSelN[3];
      next_pinOut[p6io_pkg::PIN_CS6] = altIn.chipSelN[2];
      next_pinOut[p6io_pkg::PIN_CS5] = altIn.chipSelN[1];
      next_pinOut[p6io_pkg::PIN_CS4] = altIn.chipSelN[0];
    end
    if (altIn.xferEndEnableCh1) begin
      next_pinOe[p6io_pkg::PIN_XFER_END_OUT_CH1]  = 1'b1;
      next_pinOut[p6io_pkg::PIN_XFER_END_OUT_CH1] = altIn.xferEndOutCh1N;
    end
    if (altIn.xferEndEnableCh0) begin
      next_pinOe[p6io_pkg::PIN_XFER_END_OUT_CH0]  = 1'b1;
      next_pinOut[p6io_pkg::PIN_XFER_END_OUT_CH0] = altIn.xferEndOutCh0N;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut <= p6io_pkg::RESET_BYTE;
      pinOe  <= p6io_pkg::RESET_BYTE;
      altOut <= '1;
    end else begin
      pinOut                <= next_pinOut;
      pinOe                 <= next_pinOe;
      altOut.extInt2N       <= pinSync[p6io_pkg::PIN_INT2];
      altOut.extInt1N       <= pinSync[p6io_pkg::PIN_INT1];
      altOut.extInt0N       <= pinSync[p6io_pkg::PIN_INT0];
      altOut.dmaRequestCh1N <= pinSync[p6io_pkg::PIN_DMA_REQUEST_CH1];
      altOut.dmaRequestCh0N <= pinSync[p6io_pkg::PIN_DMA_REQUEST_CH0];
    end
  end

  // merge uses the register values of the cycle the sample was taken in
  a_pin_state_merge: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hwStby || !holdState
    |=> portPinState == (($past(portDirection) & $past(portOutputData))
                       | (~$past(portDirection) & $past(pinSync))))
    else $error("pin state merge wrong");
  a_state_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    holdState && !hwStby |=> $stable(portPinState))
    else $error("pin state not held");
  a_hw_standby_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hwStby |=> portOutputData == 8'h00 && portDirection == 8'h00)
    else $error("standby clear missing");
  a_manual_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    manRst && !hwStby && !doWrite |=> $stable(portOutputData))
    else $error("data lost in manual reset");
  a_pin_state_ro: assert property (@(posedge clk_sys) disable iff (sys_rst)
    doWrite && !hwStby && awAddr == p6io_pkg::ADDR_PIN_STATE
    |=> $stable(portOutputData) && $stable(portDirection))
    else $error("pin state write had effect");
  a_dir_unreadable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == p6io_pkg::ADDR_DIRECTION
    |=> s_axi_rvalid && s_axi_rdata == p6io_pkg::UNDEF_READ)
    else $error("direction readable");
  a_xfer_end_out_ch1_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    altIn.xferEndEnableCh1 |=> pinOe[3] && pinOut[3] == $past(altIn.xferEndOutCh1N))
    else $error("xfer_end_out_ch1 not driven");
  a_xfer_end_out_ch0_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    altIn.xferEndEnableCh0 |=> pinOe[1] && pinOut[1] == $past(altIn.xferEndOutCh0N))
    else $error("xfer_end_out_ch0 not driven");
  a_cs7_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    csMode |=> pinOut[7] == $past(altIn.chipSelN[3]))
    else $error("cs7 wrong");
  a_gpio_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !csMode |=> pinOut[7] == $past(portOutputData[7]) && pinOe[7] == $past(portDirection[7]))
    else $error("gpio7 wrong");
  // the edge that releases reset still loads the idle reset values, so skip it
  a_int_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst
    |=> altOut.extInt2N == $past(pinSync[6]) && altOut.extInt1N == $past(pinSync[5])
        && altOut.extInt0N == $past(pinSync[4]))
    else $error("interrupt route wrong");
  a_dreq_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst
    |=> altOut.dmaRequestCh0N == $past(pinSync[0])
        && altOut.dmaRequestCh1N == $past(pinSync[2]))
    else $error("dma request route wrong");
endmodule
`default_nettype wire
